// ---- rtl/shift_pkg.sv ----
// Constants and types for the left-shift datapath slice with quotient register.
// Assumes big-endian bit numbering in instruction fields, mapped onto [31:0].
package shift_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int WORD_W    = 32;
  localparam int GPR_COUNT = 32;
  localparam int ADDR_W    = 8;
  localparam int AMT_W     = 5;
  localparam int IDX_W     = 5;

  // ****************************************
  // Instruction fields
  // ****************************************
  localparam int PRIM_LSB    = 26;
  localparam int OPERAND_LSB = 21;
  localparam int DEST_LSB    = 16;
  localparam int AMOUNT_LSB  = 11;
  localparam int XO_LSB      = 1;
  localparam int RECORD_POS  = 0;

  localparam logic [5:0] OPC_PRIMARY       = 6'h1f;
  localparam logic [9:0] XO_LONG_MERGE     = 10'h0d8;
  localparam logic [9:0] XO_SHIFT_QUOTIENT = 10'h098;
  localparam logic [9:0] XO_SHIFT_WORD     = 10'h018;

  // Amount register: count in bits 27-31, mask select in bit 26
  localparam int MASK_SEL_POS = 5;

  // ****************************************
  // Condition and exception fields
  // ****************************************
  localparam int CR_BELOW_POS = 3;
  localparam int CR_ABOVE_POS = 2;
  localparam int CR_ZERO_POS  = 1;
  localparam int CR_SO_POS    = 0;
  localparam int XER_SO_POS   = 31;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_QUOT   = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_CR0    = 8'h84;
  localparam logic [ADDR_W-1:0] ADDR_XER    = 8'h88;
  localparam logic [ADDR_W-1:0] ADDR_INSTR  = 8'h8c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h90;
  localparam int GPR_REGION_POS = 7;
  localparam int ST_ILLEGAL_POS = 0;
  localparam int ST_KIND_LSB    = 1;

  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [3:0]        CR_RESET   = 4'h0;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_LONG_MERGE,
    OP_SHIFT_QUOTIENT,
    OP_SHIFT_WORD
  } op_kind_t;

endpackage

// ---- rtl/shift_if.sv ----
// Interface between the core and the rotate-and-mask unit.
// Assumes purely combinational use inside one clock domain.
`timescale 1ns/1ps
`default_nettype none

interface shift_if;
  import shift_pkg::*;

  logic [WORD_W-1:0] operand;
  logic [WORD_W-1:0] amount;
  logic [WORD_W-1:0] quotient;
  op_kind_t          kind;
  logic [WORD_W-1:0] result;
  logic [WORD_W-1:0] quotient_next;
  logic              quotient_load;

  modport core
  (
    output operand, amount, quotient, kind,
    input  result, quotient_next, quotient_load
  );

  modport unit
  (
    input  operand, amount, quotient, kind,
    output result, quotient_next, quotient_load
  );
endinterface // shift_if

`default_nettype wire

// ---- rtl/rotate_mask_unit.sv ----
// Combinational rotate, mask generation and merge for the three shift forms.
// Assumes the core registers every result it takes from here.
`timescale 1ns/1ps
`default_nettype none

module rotate_mask_unit
  import shift_pkg::*;
(
  shift_if.unit sh
);

  logic [AMT_W-1:0]    n;
  logic                sel;
  logic [2*WORD_W-1:0] doubled;
  logic [WORD_W-1:0]   rotated;
  logic [WORD_W-1:0]   ones;
  logic [WORD_W-1:0]   mask;

  assign n       = sh.amount[AMT_W-1:0];
  assign sel     = sh.amount[MASK_SEL_POS];
  assign ones    = {WORD_W{1'b1}};
  assign doubled = {sh.operand, sh.operand} << n;
  assign rotated = doubled[2*WORD_W-1:WORD_W];

  // ****************************************
  // Mask and result selection
  // ****************************************
  always_comb
  begin
    mask             = ones << n;
    sh.result        = WORD_RESET;
    sh.quotient_next = rotated;
    sh.quotient_load = 1'b0;
    case (sh.kind)
      OP_LONG_MERGE:
      begin
        if (!sel)
        begin
          mask      = ones >> n;
          sh.result = (rotated & mask) | (sh.quotient & ~mask);
        end
        else
        begin
          mask      = ~(ones >> n);
          sh.result = sh.quotient & ~mask;
        end
      end
      OP_SHIFT_QUOTIENT:
      begin
        mask             = sel ? WORD_RESET : (ones << n);
        sh.result        = rotated & mask;
        sh.quotient_load = 1'b1;
      end
      OP_SHIFT_WORD:
      begin
        mask      = sel ? WORD_RESET : (ones << n);
        sh.result = rotated & mask;
      end
      default:
      begin
        sh.result = WORD_RESET;
      end
    endcase
  end

endmodule // rotate_mask_unit

`default_nettype wire

// ---- rtl/shift_left_with_quotient_reg.sv ----
// Left-shift datapath slice: register file, quotient, condition field, decoder.
// Assumes a plain register port master with one-cycle strobes, never both at once.
`timescale 1ns/1ps
`default_nettype none

module shift_left_with_quotient_reg
  import shift_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [shift_pkg::ADDR_W-1:0] addr,
  input  wire logic [shift_pkg::WORD_W-1:0] wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output var  logic [shift_pkg::WORD_W-1:0] rdata
);
  import shift_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [WORD_W-1:0] gpr_reg [GPR_COUNT];
  logic [WORD_W-1:0] multiply_quotient_reg;
  logic [3:0]        cr0_reg;
  logic [WORD_W-1:0] xer_reg;
  logic              illegal_reg;
  op_kind_t          last_kind_reg;
  logic [WORD_W-1:0] rdata_reg;

  // ****************************************
  // Decode of an issued instruction
  // ****************************************
  logic              issue;
  logic [WORD_W-1:0] instr;
  logic [5:0]        primary;
  logic [9:0]        ext_op;
  logic [IDX_W-1:0]  operand_idx;
  logic [IDX_W-1:0]  dest_idx;
  logic [IDX_W-1:0]  amount_idx;
  logic              record_flag;
  op_kind_t          kind;
  logic              legal;
  logic              exec;

  assign issue       = wr_stb && (addr == ADDR_INSTR);
  assign instr       = wdata;
  assign primary     = instr[PRIM_LSB +: 6];
  assign ext_op      = instr[XO_LSB +: 10];
  assign operand_idx = instr[OPERAND_LSB +: IDX_W];
  assign dest_idx    = instr[DEST_LSB +: IDX_W];
  assign amount_idx  = instr[AMOUNT_LSB +: IDX_W];
  assign record_flag = instr[RECORD_POS];

  always_comb
  begin
    kind = OP_NONE;
    if (primary == OPC_PRIMARY)
    begin
      case (ext_op)
        XO_LONG_MERGE:     kind = OP_LONG_MERGE;
        XO_SHIFT_QUOTIENT: kind = OP_SHIFT_QUOTIENT;
        XO_SHIFT_WORD:     kind = OP_SHIFT_WORD;
        default:           kind = OP_NONE;
      endcase
    end
  end

  assign legal = (kind != OP_NONE);
  assign exec  = issue && legal;

  // ****************************************
  // Rotate and mask unit
  // ****************************************
  shift_if sh ();

  assign sh.operand  = gpr_reg[operand_idx];
  assign sh.amount   = gpr_reg[amount_idx];
  assign sh.quotient = multiply_quotient_reg;
  assign sh.kind     = kind;

  rotate_mask_unit u_rotate
  (
    .sh (sh.unit)
  );

  // ****************************************
  // Condition field from result
  // ****************************************
  logic [3:0] cr0_next;
  logic       negative_flag;
  logic       positive_flag;
  logic       zero_flag;

  assign negative_flag = sh.result[WORD_W-1];
  assign zero_flag     = (sh.result == WORD_RESET);
  assign positive_flag = !negative_flag && !zero_flag;

  always_comb
  begin
    cr0_next               = CR_RESET;
    cr0_next[CR_BELOW_POS] = negative_flag;
    cr0_next[CR_ABOVE_POS] = positive_flag;
    cr0_next[CR_ZERO_POS]  = zero_flag;
    cr0_next[CR_SO_POS]    = xer_reg[XER_SO_POS];
  end

  // ****************************************
  // Register decode for the port
  // ****************************************
  logic             gpr_hit;
  logic [IDX_W-1:0] port_idx;

  assign gpr_hit  = !addr[GPR_REGION_POS] && (addr[1:0] == 2'b00);
  assign port_idx = addr[2 +: IDX_W];

  // ****************************************
  // Port writes to the special registers
  // ****************************************
  logic quot_wr;
  logic cr0_wr;
  logic xer_wr;
  logic status_wr;

  assign quot_wr   = wr_stb && (addr == ADDR_QUOT);
  assign cr0_wr    = wr_stb && (addr == ADDR_CR0);
  assign xer_wr    = wr_stb && (addr == ADDR_XER);
  assign status_wr = wr_stb && (addr == ADDR_STATUS);

  // ****************************************
  // General registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < GPR_COUNT; i++)
      begin
        gpr_reg[i] <= WORD_RESET;
      end
    end
    else if (exec)
    begin
      gpr_reg[dest_idx] <= sh.result;
    end
    else if (wr_stb && gpr_hit)
    begin
      gpr_reg[port_idx] <= wdata;
    end
  end

  // ****************************************
  // Quotient register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      multiply_quotient_reg <= WORD_RESET;
    end
    else if (exec && sh.quotient_load)
    begin
      multiply_quotient_reg <= sh.quotient_next;
    end
    else if (quot_wr)
    begin
      multiply_quotient_reg <= wdata;
    end
  end

  // ****************************************
  // Condition field zero
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cr0_reg <= CR_RESET;
    end
    else if (exec && record_flag)
    begin
      cr0_reg <= cr0_next;
    end
    else if (cr0_wr)
    begin
      cr0_reg <= wdata[3:0];
    end
  end

  // ****************************************
  // Exception register, software only
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      xer_reg <= WORD_RESET;
    end
    else if (xer_wr)
    begin
      xer_reg <= wdata;
    end
  end

  // ****************************************
  // Status: illegal sticky, last kind
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      illegal_reg <= 1'b0;
    end
    else if (issue && !legal)
    begin
      illegal_reg <= 1'b1;
    end
    else if (status_wr && wdata[ST_ILLEGAL_POS])
    begin
      illegal_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      last_kind_reg <= OP_NONE;
    end
    else if (issue)
    begin
      last_kind_reg <= kind;
    end
  end

  // ****************************************
  // Read port, data one cycle later
  // ****************************************
  logic [WORD_W-1:0] status_word;
  logic [WORD_W-1:0] cr0_word;
  logic [WORD_W-1:0] rdata_next;

  always_comb
  begin
    status_word                   = WORD_RESET;
    status_word[ST_ILLEGAL_POS]   = illegal_reg;
    status_word[ST_KIND_LSB +: 2] = last_kind_reg;
  end

  always_comb
  begin
    cr0_word      = WORD_RESET;
    cr0_word[3:0] = cr0_reg;
  end

  // Bus idles at zero outside the cycle after a read
  always_comb
  begin
    rdata_next = WORD_RESET;
    if (rd_stb)
    begin
      if (gpr_hit)
      begin
        rdata_next = gpr_reg[port_idx];
      end
      else
      begin
        case (addr)
          ADDR_QUOT:   rdata_next = multiply_quotient_reg;
          ADDR_CR0:    rdata_next = cr0_word;
          ADDR_XER:    rdata_next = xer_reg;
          ADDR_STATUS: rdata_next = status_word;
          default:     rdata_next = WORD_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_reg <= WORD_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule // shift_left_with_quotient_reg

`default_nettype wire

// ---- sim/shift_monitor_monitor.sv ----
// Checker on the register port of the left-shift slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module shift_monitor
(
  input wire logic                         clk,
  input wire logic                         reset,
  input wire logic [shift_pkg::ADDR_W-1:0] addr,
  input wire logic [shift_pkg::WORD_W-1:0] wdata,
  input wire logic                         wr_stb,
  input wire logic                         rd_stb,
  input wire logic [shift_pkg::WORD_W-1:0] rdata
);
  import shift_pkg::*;

  // ****************************************
  // Shadow state
  // ****************************************
  logic              xer_reg;
  logic              quot_ok_reg;
  logic [WORD_W-1:0] quot_reg;
  op_kind_t          kind;
  wire logic         ins = wr_stb && addr == ADDR_INSTR;

  always_comb
  begin
    kind = OP_NONE;
    if (wdata[31:26] == OPC_PRIMARY)
      case (wdata[10:1])
        XO_LONG_MERGE:     kind = OP_LONG_MERGE;
        XO_SHIFT_QUOTIENT: kind = OP_SHIFT_QUOTIENT;
        XO_SHIFT_WORD:     kind = OP_SHIFT_WORD;
        default:           kind = OP_NONE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      xer_reg <= 1'b0;
    else if (wr_stb && addr == ADDR_XER)
      xer_reg <= wdata[XER_SO_POS];
  end

  // Quotient value unknown here after a quotient-loading issue
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      quot_reg    <= '0;
      quot_ok_reg <= 1'b1;
    end
    else if (wr_stb && addr == ADDR_QUOT)
    begin
      quot_reg    <= wdata;
      quot_ok_reg <= 1'b1;
    end
    else if (ins && kind == OP_SHIFT_QUOTIENT)
      quot_ok_reg <= 1'b0;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == '0)
    else $error("read data not zero outside read cycle");
  instr_read_a: assert property (rd_stb && addr == ADDR_INSTR |=> rdata == '0)
    else $error("issue register read not zero");
  unmapped_read_a: assert property (rd_stb && addr > ADDR_STATUS |=> rdata == '0)
    else $error("unmapped read not zero");
  xer_kept_a: assert property (rd_stb && addr == ADDR_XER |=> rdata[XER_SO_POS] == xer_reg)
    else $error("exception register changed");
  quot_kept_a: assert property (rd_stb && addr == ADDR_QUOT && quot_ok_reg
    |=> rdata == quot_reg)
    else $error("quotient changed by non-loading form");
  decode_kind_a: assert property (ins ##1 (rd_stb && addr == ADDR_STATUS)
    |=> rdata[2:1] == $past(kind, 2))
    else $error("issued kind wrong in status");
  illegal_flag_a: assert property (ins && kind == OP_NONE ##1 (rd_stb && addr == ADDR_STATUS)
    |=> rdata[ST_ILLEGAL_POS])
    else $error("illegal flag not set");
  illegal_clear_a: assert property (wr_stb && addr == ADDR_STATUS && wdata[0]
    ##1 (rd_stb && addr == ADDR_STATUS) |=> !rdata[ST_ILLEGAL_POS])
    else $error("illegal flag not cleared");

  cover property (ins && kind == OP_LONG_MERGE);
  cover property (ins && kind == OP_SHIFT_QUOTIENT);
  cover property (ins && kind == OP_SHIFT_WORD);
endmodule // shift_monitor

`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the left-shift slice, driven over the register port.
// Assumes the package and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import shift_pkg::*;

  // ****************************************
  // Signals and model
  // ****************************************
  logic                     clk, reset, wr_stb, rd_stb, xer, ill;
  logic                     seen = 1'b0;
  logic [ADDR_W-1:0]        addr;
  logic [WORD_W-1:0]        wdata, rdata, lf, quot, amt;
  logic [4:0]               si, bi;
  logic [WORD_W-1:0]        gpr [GPR_COUNT];
  logic [3:0]               cr;
  logic [1:0]               knd;
  logic [ADDR_W+WORD_W-1:0] q [$];
  logic [ADDR_W+WORD_W-1:0] n;
  int                       mismatches, checks, cyc;

  shift_left_with_quotient_reg u_shift_left_with_quotient_reg (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task test_done;
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] s, e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error reg %h expected %h seen %h", a, e, s);
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
  endtask

  task rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
    @(posedge clk);
    addr   <= a;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    q.push_back({a, e});
  endtask

  task automatic run(input logic [1:0] k, input logic [4:0] s, d, b, input logic rc);
    logic [63:0] t;
    logic [31:0] rot, res, lo;
    logic [4:0]  c;
    logic        sel_bit;
    c = gpr[b][AMT_W-1:0];
    sel_bit = gpr[b][MASK_SEL_POS];
    t = {gpr[s], gpr[s]} << c;
    rot = t[63:32];
    lo = 32'hffff_ffff >> c;
    res = sel_bit ? '0 : rot & (32'hffff_ffff << c);
    if (k == 2'd1)
      res = sel_bit ? quot & lo : (rot & lo) | (quot & ~lo);
    if (k == 2'd2)
      quot = rot;
    if (rc)
      cr = {res[31], !res[31] && res != '0, res == '0, xer};
    gpr[d] = res;
    knd = k;
    wr(ADDR_INSTR, {OPC_PRIMARY, s, d, b,
      k == 2'd1 ? XO_LONG_MERGE : k == 2'd2 ? XO_SHIFT_QUOTIENT : XO_SHIFT_WORD, rc});
    rd(ADDR_STATUS, {29'h0, knd, ill});
    rd({1'b0, d, 2'b00}, gpr[d]);
    rd(ADDR_QUOT, quot);
    rd(ADDR_CR0, {28'h0, cr});
    rd(ADDR_XER, {xer, 31'h0});
  endtask

  // ****************************************
  // Watcher and timeout
  // ****************************************
  always @(posedge clk)
  begin
    if (seen)
    begin
      n = q.pop_front();
      chk(n[ADDR_W+WORD_W-1:WORD_W], rdata, n[WORD_W-1:0]);
    end
    seen = rd_stb;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    reset = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = '0;
    wdata = '0;
    quot = '0;
    cr = '0;
    xer = 1'b0;
    ill = 1'b0;
    knd = '0;
    lf = 32'hf692;
    foreach (gpr[i]) gpr[i] = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_STATUS, '0);
    rd(ADDR_CR0, '0);
    rd(ADDR_XER, '0);
    rd(8'h7c, '0);
    rd(ADDR_INSTR, '0);
    wr(8'ha0, 32'hffff_ffff);
    rd(8'ha0, '0);
    rd(ADDR_QUOT, '0);
    for (int i = 0; i < 48; i++)
    begin
      lf = nx(lf);
      si = lf[4:0];
      wr({1'b0, si, 2'b00}, lf);
      gpr[si] = lf;
      amt = (i < 12) ? {26'h0, i[3], {5{i[1]}}} : nx(lf);
      lf = nx(lf);
      bi = lf[14:10];
      wr({1'b0, bi, 2'b00}, amt);
      gpr[bi] = amt;
      lf = nx(lf);
      quot = lf;
      xer = lf[7];
      wr(ADDR_QUOT, quot);
      wr(ADDR_XER, {xer, 31'h0});
      lf = nx(lf);
      run(2'(1 + i % 3), si, lf[9:5], bi, lf[3]);
    end
    ill = 1'b1;
    knd = '0;
    wr(ADDR_INSTR, {6'h1e, 5'd1, 5'd2, 5'd3, XO_SHIFT_WORD, 1'b1});
    rd(ADDR_STATUS, 32'h1);
    rd(8'h08, gpr[2]);
    wr(ADDR_INSTR, {OPC_PRIMARY, 5'd1, 5'd2, 5'd3, 10'h0b8, 1'b1});
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_CR0, {28'h0, cr});
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, '0);
    @(posedge clk);
    rd_stb <= 1'b0;
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule // testbench

bind shift_left_with_quotient_reg shift_monitor u_shift_monitor (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

`default_nettype wire
